// ### core/dpr_pkg.sv
/*
 * Constants and types shared by the dual-port RAM access controller.
 * Assumes one 100 MHz clock and a word-wide RAM with one cycle read latency.
 */
// Notes on behaviour
// - When both ports request together, the local CPU is granted first unless it took the previous slot.
// - The waiting system-bus master is served once the CPU access completes.
// - Runs of accesses from both ports alternate between the two sides.
// - CPU memory addresses 00000 to 07FFF hex select the on-board RAM.
// - The slave window base selects any 128K segment of the system space.
// - Base RAM slave window sizes are 8K, 16K, 24K or 32K bytes.
// - With RAM expansion fitted, window sizes are 16K, 32K, 48K or 64K.
// - RAM outside the slave window ignores system-bus masters entirely.
// - Slave decode accepts both 16-bit and 20-bit system addresses.
// - Slave answers only while the board does not own the system bus.
// - Only off-board memory or I/O accesses are routed to the system bus.
package dpr_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned RAM_AW = 15;
   localparam int unsigned SEG_LSB = 17;
   localparam int unsigned SEG_W = 3;
   localparam int unsigned OFS_W = 18;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [19:0] LOCAL_RAM_BASE = 20'h00000;
   localparam logic [19:0] LOCAL_RAM_TOP = 20'h07fff;
   localparam logic [19:0] LOCAL_RAM_TOP_EXP = 20'h0ffff;
   localparam logic [19:0] LOCAL_IO_TOP = 20'h000ff;
   localparam logic [17:0] WIN_STEP_BASE = 18'h02000;
   localparam logic [17:0] WIN_STEP_EXP = 18'h04000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ACC_TIME_NS = 20;
   localparam int unsigned ACC_CYCLES =
      (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] ACC_LAST = 4'(ACC_CYCLES - 1);

   // ----------------------------------------------------------------
   // States and reset values
   // ----------------------------------------------------------------
   typedef enum logic {DPR_SIDE_CPU, DPR_SIDE_SYS} dpr_side_t;
   typedef enum logic [1:0] {DPR_IDLE, DPR_CPU_ACC, DPR_SYS_ACC} dpr_state_t;
   localparam dpr_side_t LAST_RESET = DPR_SIDE_SYS;
   localparam logic [3:0] CNT_RESET = 4'h0;

endpackage

// ### core/dpr_dec_if.sv
/*
 * Carrier between the arbiter and its address decoder.
 * Assumes both ends share the arbiter clock; the decoder is combinational.
 */
`timescale 1ns/100ps
interface dpr_dec_if;
   logic [19:0] cpu_addr;
   logic cpu_mem;
   logic ram_exp;
   logic [19:0] sys_addr;
   logic sys_addr20;
   logic [2:0] win_base;
   logic [1:0] win_size;
   logic cpu_hit_ram;
   logic cpu_hit_io;
   logic cpu_ext;
   logic sys_hit;
   logic [17:0] sys_offset;

   modport arb (
      output cpu_addr, cpu_mem, ram_exp, sys_addr, sys_addr20, win_base,
         win_size,
      input cpu_hit_ram, cpu_hit_io, cpu_ext, sys_hit, sys_offset
   );
   modport dec (
      input cpu_addr, cpu_mem, ram_exp, sys_addr, sys_addr20, win_base,
         win_size,
      output cpu_hit_ram, cpu_hit_io, cpu_ext, sys_hit, sys_offset
   );
endinterface

// ### core/dpr_decode.sv
/*
 * Address decoder for both ports of the RAM controller.
 * Assumes inputs are already in the arbiter clock domain.
 */
`timescale 1ns/100ps
module dpr_decode (
   dpr_dec_if.dec d
);
   logic [19:0] ram_top;
   logic [19:0] sys_eff;
   logic [17:0] step;
   logic [17:0] win_len;

   always_comb begin
      // Expansion doubles the RAM seen by the CPU
      ram_top = d.ram_exp ? dpr_pkg::LOCAL_RAM_TOP_EXP
         : dpr_pkg::LOCAL_RAM_TOP;
      d.cpu_hit_ram = d.cpu_mem && (d.cpu_addr >= dpr_pkg::LOCAL_RAM_BASE)
         && (d.cpu_addr <= ram_top);
      d.cpu_hit_io = !d.cpu_mem && (d.cpu_addr <= dpr_pkg::LOCAL_IO_TOP);
      d.cpu_ext = !d.cpu_hit_ram && !d.cpu_hit_io;
      // Short addresses carry zero upper nibble
      sys_eff = d.sys_addr20 ? d.sys_addr
         : {4'h0, d.sys_addr[15:0]};
      step = d.ram_exp ? dpr_pkg::WIN_STEP_EXP
         : dpr_pkg::WIN_STEP_BASE;
      win_len = step * (18'({16'h0000, d.win_size}) + 18'h00001);
      d.sys_offset = {1'b0, sys_eff[16:0]};
      d.sys_hit = (sys_eff[19:17] == d.win_base)
         && (d.sys_offset < win_len);
   end
endmodule

// ### core/dpr_arbiter.sv
/*
 * Dual-port RAM access controller: local CPU port and system-bus slave port
 * share one word-wide RAM with CPU priority and interleaving.
 * Assumes the CPU side runs on mclk and holds its request until acknowledged;
 * system-bus pins and straps are asynchronous and held stable around the
 * request strobe; the RAM returns read data one cycle after its select.
 */
`timescale 1ns/100ps
module dpr_arbiter (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cpu_req,
   input wire logic cpu_mem,
   input wire logic cpu_we,
   input wire logic [19:0] cpu_addr,
   input wire logic [1:0] cpu_be,
   input wire logic [15:0] cpu_wdata,
   output logic cpu_ack,
   output logic [15:0] cpu_rdata,
   output logic cpu_ext_sel,
   output logic cpu_io_sel,
   input wire logic sys_req,
   input wire logic sys_we,
   input wire logic sys_addr20,
   input wire logic [19:0] sys_addr,
   input wire logic [1:0] sys_be,
   input wire logic [15:0] sys_wdata,
   output logic sys_ack,
   output logic [15:0] sys_rdata,
   input wire logic bus_owned,
   input wire logic [2:0] win_base,
   input wire logic [1:0] win_size,
   input wire logic ram_exp,
   output logic ram_cs,
   output logic ram_we,
   output logic [14:0] ram_addr,
   output logic [1:0] ram_be,
   output logic [15:0] ram_wdata,
   input wire logic [15:0] ram_rdata
);

   // ----------------------------------------------------------------
   // Synchronisers for pins
   // ----------------------------------------------------------------
   localparam int unsigned SW = 48;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_meta;
   logic [SW-1:0] pin_sync;
   logic sys_req_s;
   logic sys_we_s;
   logic sys_addr20_s;
   logic [19:0] sys_addr_s;
   logic [1:0] sys_be_s;
   logic [15:0] sys_wdata_s;
   logic bus_owned_s;
   logic [2:0] win_base_s;
   logic [1:0] win_size_s;
   logic ram_exp_s;

   assign pin_raw = {sys_req, sys_we, sys_addr20, sys_addr, sys_be,
      sys_wdata, bus_owned, win_base, win_size, ram_exp};

   // Address and data lines settle before the strobe, so per-bit
   // synchronising is safe as long as masters keep that setup.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_meta <= '0;
      end else begin
         pin_meta <= pin_raw;
      end
   end

   // First stage feeds only this one; nothing else may read
   // a possibly metastable value
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_sync <= '0;
      end else begin
         pin_sync <= pin_meta;
      end
   end

   assign {sys_req_s, sys_we_s, sys_addr20_s, sys_addr_s, sys_be_s,
      sys_wdata_s, bus_owned_s, win_base_s, win_size_s, ram_exp_s} = pin_sync;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   dpr_dec_if dec_bus ();

   assign dec_bus.cpu_addr = cpu_addr;
   assign dec_bus.cpu_mem = cpu_mem;
   assign dec_bus.ram_exp = ram_exp_s;
   assign dec_bus.sys_addr = sys_addr_s;
   assign dec_bus.sys_addr20 = sys_addr20_s;
   assign dec_bus.win_base = win_base_s;
   assign dec_bus.win_size = win_size_s;

   dpr_decode u_decode (
      .d(dec_bus.dec)
   );

   // ----------------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------------
   dpr_pkg::dpr_state_t state;
   dpr_pkg::dpr_side_t last;
   logic [3:0] cnt;
   logic cpu_pend;
   logic sys_pend;
   logic grant_cpu;
   logic grant_sys;
   logic acc_end;

   assign cpu_pend = cpu_req && dec_bus.cpu_hit_ram && !cpu_ack;
   assign sys_pend = sys_req_s && dec_bus.sys_hit
      && !bus_owned_s && !sys_ack;
   // CPU wins a tie unless it took the previous slot
   assign grant_cpu = (state == dpr_pkg::DPR_IDLE) && cpu_pend
      && (!sys_pend || last == dpr_pkg::DPR_SIDE_SYS);
   assign grant_sys = (state == dpr_pkg::DPR_IDLE) && sys_pend
      && !grant_cpu;
   assign acc_end = (state != dpr_pkg::DPR_IDLE) && (cnt == dpr_pkg::ACC_LAST);

   // ----------------------------------------------------------------
   // Arbitration state
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state <= dpr_pkg::DPR_IDLE;
      end else begin
         case (state)
            dpr_pkg::DPR_IDLE: begin
               if (grant_cpu) begin
                  state <= dpr_pkg::DPR_CPU_ACC;
               end else if (grant_sys) begin
                  state <= dpr_pkg::DPR_SYS_ACC;
               end
            end
            dpr_pkg::DPR_CPU_ACC, dpr_pkg::DPR_SYS_ACC: begin
               // No new grant until the running access ends
               if (acc_end) begin
                  state <= dpr_pkg::DPR_IDLE;
               end
            end
            default: begin
               state <= dpr_pkg::DPR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         last <= dpr_pkg::LAST_RESET;
      end else if (grant_cpu) begin
         last <= dpr_pkg::DPR_SIDE_CPU;
      end else if (grant_sys) begin
         last <= dpr_pkg::DPR_SIDE_SYS;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cnt <= dpr_pkg::CNT_RESET;
      end else if (state == dpr_pkg::DPR_IDLE || acc_end) begin
         cnt <= dpr_pkg::CNT_RESET;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // RAM strobe
   // ----------------------------------------------------------------
   // A running access blocks every grant, so the strobe is one cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ram_cs <= 1'b0;
      end else begin
         ram_cs <= grant_cpu || grant_sys;
      end
   end

   // Write enable drops with the strobe, so no write repeats
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ram_we <= 1'b0;
      end else if (grant_cpu) begin
         ram_we <= cpu_we;
      end else if (grant_sys) begin
         ram_we <= sys_we_s;
      end else begin
         ram_we <= 1'b0;
      end
   end

   // Address, lanes and data hold after the strobe to save toggling;
   // they mean nothing while ram_cs is low
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ram_addr <= '0;
      end else if (grant_cpu) begin
         ram_addr <= cpu_addr[15:1];
      end else if (grant_sys) begin
         ram_addr <= dec_bus.sys_offset[15:1];
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ram_be <= 2'h0;
      end else if (grant_cpu) begin
         ram_be <= cpu_be;
      end else if (grant_sys) begin
         ram_be <= sys_be_s;
      end
   end

   // Write data comes from the granted side only
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ram_wdata <= 16'h0000;
      end else if (grant_cpu) begin
         ram_wdata <= cpu_wdata;
      end else if (grant_sys) begin
         ram_wdata <= sys_wdata_s;
      end
   end

   // ----------------------------------------------------------------
   // CPU answer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cpu_ack <= 1'b0;
      end else if (acc_end && state == dpr_pkg::DPR_CPU_ACC) begin
         cpu_ack <= 1'b1;
      end else if (!cpu_req) begin
         cpu_ack <= 1'b0;
      end
   end

   // Taken at every CPU access end; meaningful only for reads
   // and only while cpu_ack stands
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cpu_rdata <= 16'h0000;
      end else if (acc_end && state == dpr_pkg::DPR_CPU_ACC) begin
         cpu_rdata <= ram_rdata;
      end
   end

   // Routing flags follow the live request every cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cpu_ext_sel <= 1'b0;
      end else begin
         cpu_ext_sel <= cpu_req && dec_bus.cpu_ext;
      end
   end

   // On-board I/O stays on the internal bus
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cpu_io_sel <= 1'b0;
      end else begin
         cpu_io_sel <= cpu_req && dec_bus.cpu_hit_io;
      end
   end

   // ----------------------------------------------------------------
   // System-bus answer
   // ----------------------------------------------------------------
   // Acknowledge holds until the master drops its strobe, which is
   // what keeps one bus cycle from being served twice.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sys_ack <= 1'b0;
      end else if (acc_end && state == dpr_pkg::DPR_SYS_ACC) begin
         sys_ack <= 1'b1;
      end else if (!sys_req_s) begin
         sys_ack <= 1'b0;
      end
   end

   // Taken at every slave access end; meaningful only for reads
   // and only while sys_ack stands
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sys_rdata <= 16'h0000;
      end else if (acc_end && state == dpr_pkg::DPR_SYS_ACC) begin
         sys_rdata <= ram_rdata;
      end
   end

endmodule

// ### sim/dpr_ram_model.sv
/* Word RAM model behind the arbiter's RAM port.
   Assumes ram_cs pulses once per access on mclk. */
`timescale 1ns/100ps
module dpr_ram_model (
   input wire logic mclk,
   input wire logic ram_cs,
   input wire logic ram_we,
   input wire logic [14:0] ram_addr,
   input wire logic [1:0] ram_be,
   input wire logic [15:0] ram_wdata,
   output logic [15:0] ram_rdata
);
   logic [15:0] mem [0:32767];
   logic [15:0] hold = 16'h0;
   logic vld = 1'b0;
   // Idle bus shows inverted data except in the cycle after a read, so a late capture is caught
   assign ram_rdata = ram_cs ? mem[ram_addr] : (vld ? hold : ~hold);
   always @(posedge mclk) begin
      vld <= ram_cs & ~ram_we;
      if (ram_cs) begin
         hold <= mem[ram_addr];
      end
      if (ram_cs & ram_we & ram_be[0]) begin
         mem[ram_addr][7:0] <= ram_wdata[7:0];
      end
      if (ram_cs & ram_we & ram_be[1]) begin
         mem[ram_addr][15:8] <= ram_wdata[15:8];
      end
   end
endmodule

// ### sim/dpr_arbiter_properties.sv
/* Port checker for dpr_arbiter.
   Assumes system pins stay stable while sys_req is high. */
`timescale 1ns/100ps
module dpr_arbiter_properties (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cpu_req,
   input wire logic cpu_mem,
   input wire logic [19:0] cpu_addr,
   input wire logic cpu_ack,
   input wire logic cpu_ext_sel,
   input wire logic cpu_io_sel,
   input wire logic sys_addr20,
   input wire logic [19:0] sys_addr,
   input wire logic sys_ack,
   input wire logic bus_owned,
   input wire logic [2:0] win_base,
   input wire logic [1:0] win_size,
   input wire logic ram_exp,
   input wire logic ram_cs,
   input wire logic [14:0] ram_addr
);
   // ----------------------------------------
   // Window decode
   // ----------------------------------------
   logic [16:0] ofs;
   logic [17:0] lim;
   logic [19:0] top;
   logic hit;
   assign ofs = {sys_addr20 & sys_addr[16], sys_addr[15:0]};
   assign lim = (18'(win_size) + 18'h1) << (ram_exp ? 14 : 13);
   assign top = ram_exp ? dpr_pkg::LOCAL_RAM_TOP_EXP : dpr_pkg::LOCAL_RAM_TOP;
   assign hit = (sys_addr20 ? sys_addr[19:17] : 3'h0) == win_base &&
      18'(ofs) < lim;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   cs_pulse_a: assert property (ram_cs |=> !ram_cs)
      else $error("ram_cs longer than one cycle");
   cpu_grant_a: assert property ($rose(cpu_req) && cpu_mem &&
      cpu_addr <= top |-> ##[1:5] ram_cs && ram_addr == cpu_addr[15:1])
      else $error("local RAM request not served");
   cpu_ack_a: assert property ($rose(cpu_ack) |-> $past(ram_cs, 2) &&
      $past(ram_addr, 2) == cpu_addr[15:1])
      else $error("cpu_ack w/o access");
   ack_hold_a: assert property (cpu_ack |=>
      cpu_ack == $past(cpu_req)) else $error("cpu_ack hold wrong");
   sys_ack_a: assert property ($rose(sys_ack) |-> hit &&
      $past(ram_cs, 2) && $past(ram_addr, 2) == ofs[15:1])
      else $error("sys_ack outside window or wrong word");
   ext_sel_a: assert property (cpu_req && cpu_mem &&
      cpu_addr > top |=> cpu_ext_sel)
      else $error("off-board access not routed");
   io_sel_a: assert property (cpu_req && !cpu_mem &&
      cpu_addr <= dpr_pkg::LOCAL_IO_TOP |=> cpu_io_sel && !cpu_ext_sel)
      else $error("on-board I/O routed off-board");
   bus_owned_a: assert property (bus_owned [*6] |-> !$rose(sys_ack))
      else $error("slave answered while owning bus");
   cover property ($rose(cpu_ack));
   cover property ($rose(sys_ack));
   cover property (cpu_ack && sys_ack);
endmodule
bind dpr_arbiter dpr_arbiter_properties u_prop (.mclk, .reset_n, .cpu_req,
   .cpu_mem, .cpu_addr, .cpu_ack, .cpu_ext_sel, .cpu_io_sel, .sys_addr20,
   .sys_addr, .sys_ack, .bus_owned, .win_base, .win_size, .ram_exp, .ram_cs,
   .ram_addr);

// ### sim/testbench.sv
/* Self-checking bench for dpr_arbiter with a RAM model.
   Assumes mclk at 100 MHz and inputs driven 1 ns after each edge. */
`timescale 1ns/100ps
module testbench;
   logic mclk, reset_n, cpu_req, cpu_mem, cpu_we, cpu_ack, cpu_ext_sel;
   logic cpu_io_sel, sys_req, sys_we, sys_addr20, sys_ack, bus_owned;
   logic ram_exp, ram_cs, ram_we;
   logic [19:0] cpu_addr, sys_addr;
   logic [15:0] cpu_wdata, cpu_rdata, sys_wdata, sys_rdata;
   logic [15:0] ram_wdata, ram_rdata;
   logic [1:0] cpu_be, sys_be, ram_be, win_size;
   logic [2:0] win_base;
   logic [14:0] ram_addr;
   logic [14:0] cs_log [$];
   int fail_count = 0, n_tests = 0, cycles = 0;
   dpr_arbiter u_dut (.mclk, .reset_n, .cpu_req, .cpu_mem, .cpu_we,
      .cpu_addr, .cpu_be, .cpu_wdata, .cpu_ack, .cpu_rdata, .cpu_ext_sel,
      .cpu_io_sel, .sys_req, .sys_we, .sys_addr20, .sys_addr, .sys_be,
      .sys_wdata, .sys_ack, .sys_rdata, .bus_owned, .win_base, .win_size,
      .ram_exp, .ram_cs, .ram_we, .ram_addr, .ram_be, .ram_wdata, .ram_rdata);
   dpr_ram_model u_ram (.mclk, .ram_cs, .ram_we, .ram_addr, .ram_be,
      .ram_wdata, .ram_rdata);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (ram_cs === 1'b1) begin
         cs_log.push_back(ram_addr);
      end
      if (cycles == 3000) begin
         fail_count++;
         $display("Error run length expected 3000 seen over");
         test_done();
      end
   end
   task automatic tick(int n = 1);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cpu(logic we, logic [19:0] a, logic [15:0] d,
         output logic [15:0] q);
      {cpu_mem, cpu_we, cpu_be, cpu_addr, cpu_wdata} = {1'b1, we, 2'b11, a, d};
      cpu_req = 1;
      for (int i = 0; i < 12 && cpu_ack !== 1'b1; i++) tick();
      q = cpu_rdata;
      cpu_req = 0;
      tick(2);
   endtask
   // Slave strobe rises only after the pins had a cycle to settle
   task automatic sys(logic we, logic a20, logic [19:0] a, logic [15:0] d,
         output logic ok, output logic [15:0] q);
      {sys_we, sys_addr20, sys_be, sys_addr, sys_wdata} =
         {we, a20, 2'b11, a, d};
      tick();
      sys_req = 1;
      for (int i = 0; i < 12 && sys_ack !== 1'b1; i++) tick();
      ok = sys_ack === 1'b1;
      q = sys_rdata;
      sys_req = 0;
      tick(4);
   endtask
   task automatic straps(logic e, logic [1:0] w, logic [2:0] b);
      {ram_exp, win_size, win_base} = {e, w, b};
      tick(3);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_local();
      logic [15:0] q;
      cpu(1, 20'h07ffe, 16'ha5c3, q);
      cpu(0, 20'h07ffe, 16'h0, q);
      chk("cpu_rdata top", 20'ha5c3, 20'(q));
      chk("ram_addr top", 20'h3fff, 20'(cs_log[$]));
   endtask
   task automatic t_route();
      int n;
      n = cs_log.size();
      {cpu_mem, cpu_addr, cpu_req} = {1'b1, 20'h08000, 1'b1};
      tick(2);
      chk("cpu_ext_sel", 1, 20'(cpu_ext_sel));
      cpu_req = 0;
      tick(2);
      {cpu_mem, cpu_addr, cpu_req} = {1'b0, 20'h00010, 1'b1};
      tick(2);
      chk("cpu_io_sel", 1, 20'(cpu_io_sel));
      cpu_req = 0;
      tick(3);
      chk("ram_cs count", 20'(n), 20'(cs_log.size()));
   endtask
   task automatic t_share();
      logic ok;
      logic [15:0] q;
      straps(0, 2'h3, 3'h0);
      sys(0, 0, 20'h57ffe, 16'h0, ok, q);
      chk("sys 16-bit read", 20'ha5c3, 20'(q));
      sys(1, 1, 20'h00010, 16'h1234, ok, q);
      cpu(0, 20'h00010, 16'h0, q);
      chk("cpu sees sys write", 20'h1234, 20'(q));
      sys(0, 1, 20'h20010, 16'h0, ok, q);
      chk("sys other segment", 0, 20'(ok));
      bus_owned = 1;
      tick(3);
      sys(0, 1, 20'h00010, 16'h0, ok, q);
      chk("sys while owned", 0, 20'(ok));
      bus_owned = 0;
   endtask
   task automatic t_win();
      logic ok;
      logic [15:0] q;
      logic [19:0] sz;
      for (int e = 0; e < 2; e++) begin
         for (int w = 0; w < 4; w++) begin
            straps(e[0], w[1:0], 3'h5);
            sz = 20'(w + 1) << (13 + e);
            sys(0, 1, 20'ha0000 + sz - 20'h2, 16'h0, ok, q);
            chk("sys inside", 1, 20'(ok));
            sys(0, 1, 20'ha0000 + sz, 16'h0, ok, q);
            chk("sys outside", 0, 20'(ok));
         end
      end
   endtask
   task automatic t_prio();
      logic ok;
      logic [15:0] q;
      logic [14:0] ea [4] = '{15'h080, 15'h100, 15'h082, 15'h102};
      int n;
      straps(0, 2'h3, 3'h0);
      n = cs_log.size();
      fork
         begin
            sys(1, 1, 20'h00200, 16'h1111, ok, q);
            sys(1, 1, 20'h00204, 16'h2222, ok, q);
         end
         begin
            // CPU request meets the freshly synced slave strobe, so both
            // sides contend at one idle edge after a slave grant
            tick(3);
            cpu(1, 20'h00100, 16'h3333, q);
            cpu(1, 20'h00104, 16'h4444, q);
         end
      join
      for (int i = 0; i < 4; i++) begin
         chk("grant order", 20'(ea[i]), 20'(cs_log[n + i]));
      end
   endtask
   task automatic test_done();
      $display("Tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      {reset_n, cpu_req, cpu_mem, cpu_we, cpu_addr, cpu_be, cpu_wdata} = '0;
      {sys_req, sys_we, sys_addr20, sys_addr, sys_be, sys_wdata} = '0;
      {bus_owned, win_base, win_size, ram_exp} = '0;
      tick(12);
      reset_n = 1;
      t_local();
      t_route();
      t_share();
      t_win();
      t_prio();
      test_done();
   end
endmodule
